// *** src/floppy_output_params.svh ***
// Purpose: register offsets, field positions and reset values for the floppy output config bits
// Assumes: 8-bit register port
// Notes:   definitions only
`ifndef FLOPPY_OUTPUT_PARAMS_SVH
`define FLOPPY_OUTPUT_PARAMS_SVH

`define MODE_REG_ADDR      8'hF0
`define OPTION_REG_ADDR    8'hF1
`define MODE_RESERVED_BIT  5
`define MODE_TYPE_BIT      6
`define MODE_TRISTATE_BIT  7
`define OPTION_DENS_LSB    2
`define OPTION_DENS_MSB    3
`define MODE_RESET_VALUE   8'h00
`define OPTION_RESET_VALUE 8'h00
`define MODE_READ_MASK     8'hC0
`define OPTION_READ_MASK   8'h0C

`endif

// *** src/floppy_output_pkg.sv ***
// Purpose: types shared by the floppy output config bits
// Assumes: nothing
// Notes:   density codes as software writes them
package floppy_output_pkg;

    typedef enum logic [1:0] {
        DENS_NORMAL      = 2'h0,
        DENS_NORMAL_USER = 2'h1,
        DENS_FORCE_HIGH  = 2'h2,
        DENS_FORCE_LOW   = 2'h3
    } density_sel_t;

endpackage

// *** src/floppy_output_config_bits.sv ***
// Purpose: mode/option bits steering the floppy controller's pin drivers
// Assumes: core levels arrive on clock_in; pins resolved outside
// Notes:   every output registered, so pins follow their causes by one cycle
//
// Behaviour
// RULE1: type bit 6 low gives open-drain drivers, high gives push-pull; open-drain default.
// RULE2: control bit 7 high tri-states floppy outputs; low keeps them driven, the default.
// RULE3: bits 6 and 7 leave the parallel port floppy pins untouched.
// RULE4: software keeps mode bit 5 at zero; it is reserved.
// RULE5: density codes 00/01 normal, 10 forces high, 11 forces low.
// RULE6: software writes zero to option bits 1 to 0.
// RULE7: option register at 0xF1 is read/write and resets to 0x00.
//
// The strobed register port was decided locally.
`include "floppy_output_params.svh"

module floppy_output_config_bits #(
    parameter int CTL_WIDTH = 8,
    parameter int PP_WIDTH  = 8
) (
    input  wire logic                 clock_in,
    input  wire logic                 nrst_in,
    input  wire logic                 enable_in,
    input  wire logic [7:0]           addr_in,
    input  wire logic [7:0]           wdata_in,
    input  wire logic                 wr_in,
    input  wire logic                 rd_in,
    output logic      [7:0]           rdata_out,
    input  wire logic [CTL_WIDTH-1:0] ctl_level_in,
    input  wire logic                 density_in,
    input  wire logic [PP_WIDTH-1:0]  pp_level_in,
    input  wire logic [PP_WIDTH-1:0]  pp_oe_in,
    output logic      [CTL_WIDTH-1:0] pin_out,
    output logic      [CTL_WIDTH-1:0] pin_oe_out,
    output logic                      density_pin_out,
    output logic                      density_oe_out,
    output logic      [PP_WIDTH-1:0]  pp_pin_out,
    output logic      [PP_WIDTH-1:0]  pp_oe_out
);

    logic [7:0]                    mode_reg;
    logic [7:0]                    option_reg;
    logic                          push_pull;
    logic                          tristate;
    floppy_output_pkg::density_sel_t density_sel;
    logic                          density_next;

    assign push_pull   = mode_reg[`MODE_TYPE_BIT];
    assign tristate    = mode_reg[`MODE_TRISTATE_BIT];
    assign density_sel = floppy_output_pkg::density_sel_t'(option_reg[`OPTION_DENS_MSB:`OPTION_DENS_LSB]);

    // open-drain drives low only, so a high level means release
    function automatic logic [1:0] drive(input logic level, input logic pp, input logic off);
        if (off) begin
            drive = 2'h0;
        end else if (pp) begin
            drive = {level, 1'b1};
        end else begin
            drive = {1'b0, ~level};
        end
    endfunction

    // reserved bits are not stored so they always read zero
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_reg <= `MODE_RESET_VALUE;
        end else if (enable_in && wr_in && addr_in == `MODE_REG_ADDR) begin
            mode_reg <= wdata_in & `MODE_READ_MASK; // RULE4
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            option_reg <= `OPTION_RESET_VALUE; // RULE7
        end else if (enable_in && wr_in && addr_in == `OPTION_REG_ADDR) begin
            option_reg <= wdata_in & `OPTION_READ_MASK; // RULE7 RULE6
        end
    end

    // read data stands until the next enabled cycle; unmapped and idle read zero
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 8'h00;
        end else if (enable_in) begin
            if (rd_in && addr_in == `MODE_REG_ADDR) begin
                rdata_out <= mode_reg;
            end else if (rd_in && addr_in == `OPTION_REG_ADDR) begin
                rdata_out <= option_reg; // RULE7
            end else begin
                rdata_out <= 8'h00;
            end
        end
    end

    always_comb begin
        case (density_sel)
            floppy_output_pkg::DENS_FORCE_HIGH: density_next = 1'b1; // RULE5
            floppy_output_pkg::DENS_FORCE_LOW:  density_next = 1'b0; // RULE5
            default:                            density_next = density_in; // RULE5
        endcase
    end

    // reset leaves every floppy pin released
    generate
        for (genvar i = 0; i < CTL_WIDTH; i++) begin : g_pin
            always_ff @(posedge clock_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    pin_out[i]    <= 1'b0;
                    pin_oe_out[i] <= 1'b0;
                end else if (enable_in) begin
                    {pin_out[i], pin_oe_out[i]} <= drive(ctl_level_in[i], push_pull, tristate); // RULE1 RULE2
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            density_pin_out <= 1'b0;
            density_oe_out  <= 1'b0;
        end else if (enable_in) begin
            {density_pin_out, density_oe_out} <= drive(density_next, push_pull, tristate); // RULE1 RULE2
        end
    end

    // parallel port pins keep their own enables, mode bits not consulted
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pp_pin_out <= '0;
            pp_oe_out  <= '0;
        end else if (enable_in) begin
            pp_pin_out <= pp_level_in; // RULE3
            pp_oe_out  <= pp_oe_in; // RULE3
        end
    end

    // level a pulled-up line shows
    logic density_line;
    assign density_line = density_oe_out ? density_pin_out : 1'b1;

    sequence s_opt_write;
        enable_in && wr_in && addr_in == `OPTION_REG_ADDR;
    endsequence

    sequence s_opt_read;
        enable_in && rd_in && !wr_in && addr_in == `OPTION_REG_ADDR;
    endsequence

    sequence s_mode_write;
        enable_in && wr_in && addr_in == `MODE_REG_ADDR;
    endsequence

    sequence s_mode_read;
        enable_in && rd_in && !wr_in && addr_in == `MODE_REG_ADDR;
    endsequence

    a_open_drain_pins: assert property ( // RULE1
        @(posedge clock_in) disable iff (!nrst_in)
        enable_in && !mode_reg[`MODE_TYPE_BIT] && !mode_reg[`MODE_TRISTATE_BIT]
        |=> pin_out == '0 && pin_oe_out == ~$past(ctl_level_in))
        else $error("open-drain pins not driven low-only");

    a_push_pull_pins: assert property ( // RULE1
        @(posedge clock_in) disable iff (!nrst_in)
        enable_in && mode_reg[`MODE_TYPE_BIT] && !mode_reg[`MODE_TRISTATE_BIT]
        |=> pin_out == $past(ctl_level_in) && pin_oe_out == '1)
        else $error("push-pull pins not driven both ways");

    a_tristate_pins: assert property ( // RULE2
        @(posedge clock_in) disable iff (!nrst_in)
        enable_in && mode_reg[`MODE_TRISTATE_BIT] |=> pin_oe_out == '0 && !density_oe_out)
        else $error("tri-stated pins still enabled");

    a_parallel_untouched: assert property ( // RULE3
        @(posedge clock_in) disable iff (!nrst_in)
        enable_in |=> pp_pin_out == $past(pp_level_in) && pp_oe_out == $past(pp_oe_in))
        else $error("parallel port pins altered");

    a_density_high: assert property ( // RULE5
        @(posedge clock_in) disable iff (!nrst_in)
        enable_in && !tristate && density_sel == floppy_output_pkg::DENS_FORCE_HIGH |=> density_line)
        else $error("density not forced high");

    a_density_low: assert property ( // RULE5
        @(posedge clock_in) disable iff (!nrst_in)
        enable_in && !tristate && density_sel == floppy_output_pkg::DENS_FORCE_LOW
        |=> density_oe_out && !density_line)
        else $error("density not forced low");

    a_density_normal: assert property ( // RULE5
        @(posedge clock_in) disable iff (!nrst_in)
        enable_in && !tristate && !density_sel[1] |=> density_line == $past(density_in))
        else $error("density not following core");

    a_option_readback: assert property ( // RULE7
        @(posedge clock_in) disable iff (!nrst_in)
        s_opt_write ##1 s_opt_read |=> rdata_out == ($past(wdata_in, 2) & `OPTION_READ_MASK))
        else $error("option register readback wrong");

    a_mode_readback: assert property ( // RULE1 RULE2
        @(posedge clock_in) disable iff (!nrst_in)
        s_mode_write ##1 s_mode_read |=> rdata_out == ($past(wdata_in, 2) & `MODE_READ_MASK))
        else $error("mode register readback wrong");

    a_density_open_drain: assert property ( // RULE1
        @(posedge clock_in) disable iff (!nrst_in)
        enable_in && !push_pull && !tristate |=> !density_pin_out)
        else $error("density pin driven high in open-drain");

    a_read_idle: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        enable_in && !rd_in |=> rdata_out == 8'h00)
        else $error("read data not cleared when idle");

    // a low clock enable must hold every register and pin
    a_pins_frozen: assert property (
        @(posedge clock_in) disable iff (!nrst_in)
        !enable_in |=> $stable(pin_out) && $stable(pin_oe_out) && $stable(density_pin_out)
            && $stable(density_oe_out) && $stable(pp_pin_out) && $stable(pp_oe_out))
        else $error("pins moved while clock enable low");

    a_regs_frozen: assert property ( // RULE7
        @(posedge clock_in) disable iff (!nrst_in)
        !enable_in |=> $stable(mode_reg) && $stable(option_reg) && $stable(rdata_out))
        else $error("registers moved while clock enable low");

endmodule

// *** verification/tb_floppy_output_config_bits.sv ***
// Purpose: self-checking bench for the floppy output config bits
// Assumes: mode register at 0xF0, one-cycle read latency, pins one cycle behind causes
// Notes:   walks every mode/density code mix, with two density/level pairs, through one loop
`include "floppy_output_params.svh"

module tb_floppy_output_config_bits;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clock_in     = 1'b0;
    logic       nrst_in      = 1'b0;
    logic       enable_in    = 1'b1;
    logic       wr_in        = 1'b0;
    logic       rd_in        = 1'b0;
    logic       density_in   = 1'b0;
    logic [7:0] addr_in      = 8'h00;
    logic [7:0] wdata_in     = 8'h00;
    logic [7:0] ctl_level_in = 8'h5A;
    logic [7:0] pp_level_in  = 8'hA5;
    logic [7:0] pp_oe_in     = 8'h3C;
    logic [7:0] rdata_out, pin_out, pin_oe_out, pp_pin_out, pp_oe_out;
    logic       density_pin_out, density_oe_out;
    int         failures = 0;
    int         samples_checked = 0;

    always #4 clock_in = ~clock_in;

    floppy_output_config_bits dut (.clock_in(clock_in), .nrst_in(nrst_in), .enable_in(enable_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .ctl_level_in(ctl_level_in), .density_in(density_in), .pp_level_in(pp_level_in),
        .pp_oe_in(pp_oe_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
        .density_pin_out(density_pin_out), .density_oe_out(density_oe_out),
        .pp_pin_out(pp_pin_out), .pp_oe_out(pp_oe_out));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in    <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clock_in);
        rd_in   <= 1'b0;
        #1 chk("rdata", rdata_out, exp);
    endtask

    // write then read with no gap, as the port allows
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clock_in);
        wr_in    <= 1'b0;
        rd_in    <= 1'b1;
        @(posedge clock_in);
        rd_in    <= 1'b0;
        #1 chk("rdata_b2b", rdata_out, exp);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        #20000;
        failures++;
        summarize();
    end

    initial begin
        logic [7:0] mode, lvl, eo;
        logic       dv, deo;
        repeat (4) @(posedge clock_in);
        nrst_in <= 1'b1;
        rd(`OPTION_REG_ADDR, `OPTION_RESET_VALUE);
        rd(`MODE_REG_ADDR, `MODE_RESET_VALUE);
        wr(`OPTION_REG_ADDR, 8'h0C);
        rd(`OPTION_REG_ADDR, 8'h0C);
        rd(8'h33, 8'h00);
        $display("test registers done");
        // clock enable low: a write and a new level must both be held off
        @(posedge clock_in);
        enable_in    <= 1'b0;
        ctl_level_in <= 8'hFF;
        addr_in      <= `OPTION_REG_ADDR;
        wdata_in     <= 8'h08;
        wr_in        <= 1'b1;
        @(posedge clock_in);
        wr_in        <= 1'b0;
        @(posedge clock_in);
        enable_in    <= 1'b1;
        #1 chk("frozen_pin_oe", pin_oe_out, 8'hA5);
        rd(`OPTION_REG_ADDR, 8'h0C);
        chk("resumed_pin_oe", pin_oe_out, 8'h00);
        wr_rd(`MODE_REG_ADDR, 8'h40, 8'h40);
        wr_rd(`OPTION_REG_ADDR, 8'h08, 8'h08);
        $display("test enable done");
        for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 4; c++) begin
                for (int d = 0; d < 2; d++) begin
                    mode = {m[1:0], 6'h00};
                    lvl  = d ? 8'h5A : 8'hC3;
                    wr(`MODE_REG_ADDR, mode);
                    wr(`OPTION_REG_ADDR, {4'h0, c[1:0], 2'h0});
                    density_in   <= d[0];
                    ctl_level_in <= lvl;
                    pp_level_in  <= ~lvl;
                    pp_oe_in     <= lvl ^ 8'h0F;
                    repeat (2) @(posedge clock_in);
                    #1;
                    eo  = mode[7] ? 8'h00 : (mode[6] ? 8'hFF : ~lvl);
                    dv  = (c == 2) ? 1'b1 : ((c == 3) ? 1'b0 : d[0]);
                    deo = mode[7] ? 1'b0 : (mode[6] ? 1'b1 : ~dv);
                    chk("pin_oe", pin_oe_out, eo);
                    chk("pin_drive", pin_out & eo, mode[6] ? (lvl & eo) : 8'h00);
                    chk("pp_pin", pp_pin_out, ~lvl);
                    chk("pp_oe", pp_oe_out, lvl ^ 8'h0F);
                    chk("density_oe", {7'h00, density_oe_out}, {7'h00, deo});
                    chk("density_drive", {7'h00, density_pin_out & deo}, {7'h00, dv & deo & mode[6]});
                end
            end
        end
        rd(`MODE_REG_ADDR, 8'hC0);
        $display("test drivers done");
        // second reset mid-run must clear the option field again
        @(posedge clock_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        nrst_in <= 1'b1;
        rd(`OPTION_REG_ADDR, `OPTION_RESET_VALUE);
        rd(`MODE_REG_ADDR, `MODE_RESET_VALUE);
        $display("test reset done");
        summarize();
    end
endmodule
